// ### sep_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_consts.svh"
module sep_core (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        sclk_in,
    input  wire logic        nsel_in,
    input  wire logic        sdi_in,
    input  wire logic        npause_in,
    input  wire logic        nguard_in,
    input  wire logic        write_done_in,
    input  wire logic [1:0]  nv_prot_in,
    input  wire logic        nv_lock_in,
    input  wire logic        arr_data_rd_ready_in,
    input  wire logic [7:0]  arr_rd_data_in,
    output var  logic        sdo_out,
    output var  logic        sdo_oe_out,
    output var  logic        arr_write_go_out,
    output var  logic        stat_write_go_out,
    output var  logic [7:0]  stat_write_val_out,
    output var  logic [15:0] addr_out,
    output var  logic        arr_read_req_out,
    output var  logic [7:0]  arr_data_out,
    output var  logic        arr_data_valid_out,
    output var  logic        fifo_full_out
);
    logic [2:0]  sclk_s, nsel_s, npause_s;
    logic [1:0]  sdi_s, nguard_s;
    logic        sclk_r, sclk_f, sel_f, sel_r, sclk_lvl, sel_lvl;
    logic        pause_f;
    assign sclk_lvl = sclk_s[1];
    assign sel_lvl  = !nsel_s[1];
    assign sclk_r   = sclk_s[1] && !sclk_s[2];
    assign sclk_f   = !sclk_s[1] && sclk_s[2];
    assign sel_f    = !nsel_s[1] && nsel_s[2];
    assign sel_r    = nsel_s[1] && !nsel_s[2];
    assign pause_f  = !npause_s[1] && npause_s[2];

    sep_pkg::sep_state_type st_q, st_d;
    logic [7:0]  sh_q, sh_d, op_q, op_d, out_q, out_d;
    logic [2:0]  bit_q, bit_d;
    logic [1:0]  abyte_q, abyte_d;
    logic [15:0] addr_q, addr_d;
    logic        armed_q, armed_d, pause_q, pause_d;
    logic        latch_q, latch_d, busy_q, busy_d;
    logic        dbyte_q, dbyte_d;
    logic        sdo_q, sdo_d, oe_q, oe_d;
    logic        awgo_q, awgo_d, swgo_q, swgo_d, rreq_q, rreq_d;
    logic [7:0]  swv_q, swv_d;
    logic        push, fifo_rdy, fifo_clr, full_q, full_d;
    logic        hard_lock_mode, prot_hit, cmd_whole;
    logic [7:0]  stat_byte;
    logic [15:0] prot_base;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sclk_s   <= 3'h0;
            nsel_s   <= 3'h7;
            sdi_s    <= 2'h0;
            npause_s <= 3'h7;
            nguard_s <= 2'h3;
        end
        else
        begin
            sclk_s   <= {sclk_s[1:0], sclk_in};
            nsel_s   <= {nsel_s[1:0], nsel_in};
            sdi_s    <= {sdi_s[0], sdi_in};
            npause_s <= {npause_s[1:0], npause_in};
            nguard_s <= {nguard_s[0], nguard_in};
        end
    end

    assign hard_lock_mode = nv_lock_in && !nguard_s[1];
    always_comb
    begin
        stat_byte = 8'h00;
        stat_byte[`SEP_BIT_BUSY]    = busy_q;
        stat_byte[`SEP_BIT_LATCH]   = latch_q;
        stat_byte[`SEP_BIT_PROT_LO] = nv_prot_in[0];
        stat_byte[`SEP_BIT_PROT_HI] = nv_prot_in[1];
        stat_byte[`SEP_BIT_LOCK]    = nv_lock_in;
        case (nv_prot_in)
            2'b01:   prot_base = `SEP_PROT_QUARTER;
            2'b10:   prot_base = `SEP_PROT_HALF;
            default: prot_base = `SEP_PROT_ALL;
        endcase
        prot_hit = (nv_prot_in != 2'b00) && (addr_q >= prot_base);
    end
    assign cmd_whole = (bit_q == 3'h0);

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        op_d = op_q;
        out_d = out_q;
        bit_d = bit_q;
        abyte_d = abyte_q;
        addr_d = addr_q;
        armed_d = armed_q;
        pause_d = pause_q;
        latch_d = latch_q;
        busy_d = busy_q;
        dbyte_d = dbyte_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        swv_d = swv_q;
        full_d = !fifo_rdy;
        awgo_d = 1'b0;
        swgo_d = 1'b0;
        rreq_d = 1'b0;
        push = 1'b0;
        fifo_clr = 1'b0;
        if (write_done_in && busy_q)
        begin
            busy_d  = 1'b0;
            latch_d = 1'b0;
        end
        // entry edge only honoured while clock low
        if (sel_lvl && !sclk_lvl && pause_f)
            pause_d = 1'b1;
        if (pause_q && !sclk_lvl && npause_s[1])
            pause_d = 1'b0;
        if (sel_f)
        begin
            armed_d = 1'b1;
            st_d = sep_pkg::SEP_OPCODE;
            bit_d = 3'h0;
            abyte_d = 2'h0;
            dbyte_d = 1'b0;
            fifo_clr = 1'b1;
        end
        else if (sel_r)
        begin
            oe_d = 1'b0;
            pause_d = 1'b0;
            if (cmd_whole && st_q == sep_pkg::SEP_WAIT)
            begin
                if (op_q == `SEP_OP_SET_LATCH)
                    latch_d = 1'b1;
                else if (op_q == `SEP_OP_CLR_LATCH)
                    latch_d = 1'b0;
            end
            if (cmd_whole && st_q == sep_pkg::SEP_DATA && latch_q && !busy_q)
            begin
                if (op_q == `SEP_OP_ARR_WRITE && dbyte_q && !prot_hit)
                begin
                    awgo_d = 1'b1;
                    busy_d = 1'b1;
                end
                if (op_q == `SEP_OP_STAT_WRITE && dbyte_q && !hard_lock_mode)
                begin
                    swgo_d = 1'b1;
                    busy_d = 1'b1;
                end
            end
            st_d = sep_pkg::SEP_IDLE;
        end
        else if (armed_q && sel_lvl && !pause_q)
        begin
            if (sclk_r && st_q != sep_pkg::SEP_IDLE
                && st_q != sep_pkg::SEP_DEAD)
            begin
                sh_d = {sh_q[6:0], sdi_s[1]};
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7)
                begin
                    case (st_q)
                        sep_pkg::SEP_OPCODE:
                        begin
                            op_d = {sh_q[6:0], sdi_s[1]};
                            case ({sh_q[6:0], sdi_s[1]})
                                `SEP_OP_SET_LATCH,
                                `SEP_OP_CLR_LATCH: st_d = sep_pkg::SEP_WAIT;
                                `SEP_OP_STAT_READ:
                                begin
                                    st_d = sep_pkg::SEP_STATUS;
                                    out_d = stat_byte;
                                end
                                `SEP_OP_STAT_WRITE: st_d = sep_pkg::SEP_DATA;
                                `SEP_OP_ARR_READ,
                                `SEP_OP_ARR_WRITE: st_d = sep_pkg::SEP_ADDR;
                                default: st_d = sep_pkg::SEP_DEAD;
                            endcase
                        end
                        sep_pkg::SEP_ADDR:
                        begin
                            addr_d = {addr_q[7:0], sh_q[6:0], sdi_s[1]};
                            abyte_d = abyte_q + 2'h1;
                            if (abyte_q == 2'h1)
                            begin
                                if (op_q == `SEP_OP_ARR_READ)
                                begin
                                    st_d = busy_q ? sep_pkg::SEP_DEAD
                                                  : sep_pkg::SEP_STATUS;
                                    rreq_d = !busy_q;
                                end
                                else
                                    st_d = sep_pkg::SEP_DATA;
                            end
                        end
                        sep_pkg::SEP_DATA:
                        begin
                            dbyte_d = 1'b1;
                            swv_d = {sh_q[6:0], sdi_s[1]};
                            push = op_q == `SEP_OP_ARR_WRITE;
                        end
                        sep_pkg::SEP_STATUS:
                        begin
                            if (op_q == `SEP_OP_STAT_READ)
                                out_d = stat_byte;
                            else
                            begin
                                addr_d = addr_q + 16'h0001;
                                rreq_d = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            if (sclk_f && st_q == sep_pkg::SEP_STATUS)
            begin
                oe_d = 1'b1;
                // array byte fetched once the new address has settled
                if (bit_q == 3'h0 && op_q == `SEP_OP_ARR_READ)
                begin
                    out_d = arr_rd_data_in;
                    sdo_d = arr_rd_data_in[7];
                end
                else
                    sdo_d = out_q[3'h7 - bit_q];
            end
        end
        if (pause_d)
            oe_d = 1'b0;
        else if (pause_q && sel_lvl && st_q == sep_pkg::SEP_STATUS)
            oe_d = 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_q <= sep_pkg::SEP_IDLE;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            out_q <= 8'h00;
            bit_q <= 3'h0;
            abyte_q <= 2'h0;
            addr_q <= 16'h0000;
            armed_q <= 1'b0;
            pause_q <= 1'b0;
            latch_q <= 1'b0;
            busy_q <= 1'b0;
            dbyte_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            awgo_q <= 1'b0;
            swgo_q <= 1'b0;
            rreq_q <= 1'b0;
            swv_q <= 8'h00;
            full_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            op_q <= op_d;
            out_q <= out_d;
            bit_q <= bit_d;
            abyte_q <= abyte_d;
            addr_q <= addr_d;
            armed_q <= armed_d;
            pause_q <= pause_d;
            latch_q <= latch_d;
            busy_q <= busy_d;
            dbyte_q <= dbyte_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            awgo_q <= awgo_d;
            swgo_q <= swgo_d;
            rreq_q <= rreq_d;
            swv_q <= swv_d;
            full_q <= full_d;
        end
    end

    sep_fifo #(
        .WIDTH (8),
        .DEPTH (`SEP_FIFO_DEPTH),
        .AW    (`SEP_FIFO_AW)
    ) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .nrst_in      (nrst_in),
        .clear_in     (fifo_clr),
        .wr_data_in   (sh_d),
        .wr_valid_in  (push),
        .wr_ready_out (fifo_rdy),
        .rd_data_out  (arr_data_out),
        .rd_valid_out (arr_data_valid_out),
        .rd_ready_in  (arr_data_rd_ready_in)
    );

    assign sdo_out            = sdo_q;
    assign sdo_oe_out         = oe_q;
    assign arr_write_go_out   = awgo_q;
    assign stat_write_go_out  = swgo_q;
    assign stat_write_val_out = swv_q;
    assign addr_out           = addr_q;
    assign arr_read_req_out   = rreq_q;
    assign fifo_full_out      = full_q;
endmodule
`default_nettype wire

// ### sep_consts.svh
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
`define SEP_OP_SET_LATCH   8'h06
`define SEP_OP_CLR_LATCH   8'h04
`define SEP_OP_STAT_READ   8'h05
`define SEP_OP_STAT_WRITE  8'h01
`define SEP_OP_ARR_READ    8'h03
`define SEP_OP_ARR_WRITE   8'h02
`define SEP_BIT_BUSY       0
`define SEP_BIT_LATCH      1
`define SEP_BIT_PROT_LO    2
`define SEP_BIT_PROT_HI    3
`define SEP_BIT_LOCK       7
`define SEP_PROT_QUARTER   16'hc000
`define SEP_PROT_HALF      16'h8000
`define SEP_PROT_ALL       16'h0000
`define SEP_FIFO_DEPTH     16
`define SEP_FIFO_AW        4
`endif

// ### sep_pkg.sv
package sep_pkg;
    typedef enum logic [2:0] {
        SEP_IDLE   = 3'b000,
        SEP_OPCODE = 3'b001,
        SEP_ADDR   = 3'b011,
        SEP_DATA   = 3'b010,
        SEP_STATUS = 3'b110,
        SEP_WAIT   = 3'b111,
        SEP_DEAD   = 3'b101
    } sep_state_type;
endpackage

// ### sep_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output var  logic             wr_ready_out,
    output var  logic [WIDTH-1:0] rd_data_out,
    output var  logic             rd_valid_out,
    input  wire logic             rd_ready_in
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    always_comb
    begin
        wr_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
        rd_valid_out = wp_q != rp_q;
        rd_data_out  = mem_q[rp_q[AW-1:0]];
        push = wr_valid_in && wr_ready_out;
        pop  = rd_valid_out && rd_ready_in;
        wp_d = clear_in ? '0 : wp_q + (AW+1)'(push);
        rp_d = clear_in ? '0 : rp_q + (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
endmodule
`default_nettype wire

// ### sep_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sep_core_assertions (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        sclk_in,
    input  wire logic        nsel_in,
    input  wire logic        npause_in,
    input  wire logic        nguard_in,
    input  wire logic [1:0]  nv_prot_in,
    input  wire logic        nv_lock_in,
    input  wire logic        sdo_out,
    input  wire logic        sdo_oe_out,
    input  wire logic        arr_write_go_out,
    input  wire logic        stat_write_go_out,
    input  wire logic [15:0] addr_out
);
    wire logic in_prot = nv_prot_in == 2'b11 ||
        (nv_prot_in == 2'b10 && addr_out[15]) ||
        (nv_prot_in == 2'b01 && addr_out[15:14] == 2'b11);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    sequence s_paused;
        !npause_in [*5];
    endsequence
    sequence s_go;
        arr_write_go_out || stat_write_go_out;
    endsequence
    property p_pause_off; s_paused |-> !sdo_oe_out; endproperty
    a_pause_off: assert property (p_pause_off)
        else $error("serial out driven while paused");
    property p_awr_pulse; arr_write_go_out |=> !arr_write_go_out; endproperty
    a_awr_pulse: assert property (p_awr_pulse)
        else $error("array write start longer than one cycle");
    property p_swr_pulse; stat_write_go_out |=> !stat_write_go_out; endproperty
    a_swr_pulse: assert property (p_swr_pulse)
        else $error("status write start longer than one cycle");
    property p_go_desel; s_go |-> nsel_in && $past(nsel_in); endproperty
    a_go_desel: assert property (p_go_desel)
        else $error("write started while selected");
    property p_lock; stat_write_go_out |-> !(nv_lock_in && !nguard_in); endproperty
    a_lock: assert property (p_lock)
        else $error("status write under hard lock");
    property p_prot; arr_write_go_out |-> !in_prot; endproperty
    a_prot: assert property (p_prot)
        else $error("array write into protected region");
    property p_sdo_fall;
        sdo_oe_out && $past(sdo_oe_out) && $changed(sdo_out) |-> !sclk_in;
    endproperty
    a_sdo_fall: assert property (p_sdo_fall)
        else $error("serial out changed with clock high");
    property p_reset; $rose(nrst_in) |-> !sdo_oe_out && !arr_write_go_out;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs active after reset");
endmodule
bind sep_core sep_core_assertions i_chk (.*);
`default_nettype wire

// ### sep_master.sv
`timescale 1ns/1ps
`default_nettype none
module sep_master (
    input  wire logic clk_sys_in,
    input  wire logic sdo_in,
    output var  logic sclk_out,
    output var  logic nsel_out,
    output var  logic sdi_out,
    output var  logic npause_out
);
    initial
    begin
        sclk_out = 1'b0;
        nsel_out = 1'b1;
        sdi_out = 1'b0;
        npause_out = 1'b1;
    end
    task automatic half(input int n);
        repeat (10 * n) @(negedge clk_sys_in);
    endtask
    task automatic sel(input logic s);
        nsel_out = s;
        sdi_out = ~sdi_out; // released line shows no stale value
        half(2);
    endtask
    task automatic shift(input int n, input logic [7:0] tx,
                         output logic [7:0] rx);
        for (int i = 0; i < n; i++)
        begin
            sdi_out = tx[7 - i];
            half(1);
            sclk_out = 1'b1;
            rx = {rx[6:0], sdo_in};
            half(1);
            sclk_out = 1'b0;
        end
    endtask
    // entered only while selected, clock low; fr also releases it after deselect
    task automatic pause(input logic p);
        npause_out = p;
        half(1);
    endtask
endmodule
`default_nettype wire

// ### sep_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_consts.svh"
module sep_core_test;
    logic        clk_sys_in, nrst_in, sclk_in, nsel_in, sdi_in, npause_in;
    logic        nguard_in, write_done_in, nv_lock_in, arr_data_rd_ready_in;
    logic        sdo_out, sdo_oe_out, arr_write_go_out, stat_write_go_out;
    logic        arr_read_req_out, arr_data_valid_out, fifo_full_out;
    logic [1:0]  nv_prot_in;
    logic [7:0]  arr_rd_data_in, stat_write_val_out, arr_data_out;
    logic [7:0]  rx, sval, last_wd;
    logic [15:0] addr_out;
    int          failures, comparisons, n_awr, n_swr, n_rrq;
    sep_core i_dut (.*);
    // array model: byte follows both address bytes
    assign arr_rd_data_in = addr_out[15:8] ^ addr_out[7:0];
    sep_master i_mst (
        .clk_sys_in (clk_sys_in),
        .sdo_in     (sdo_oe_out ? sdo_out : ~sdo_out),
        .sclk_out   (sclk_in),
        .nsel_out   (nsel_in),
        .sdi_out    (sdi_in),
        .npause_out (npause_in)
    );
    always @(posedge clk_sys_in)
    begin
        if (arr_write_go_out)
            n_awr++;
        if (stat_write_go_out)
            n_swr++;
        if (stat_write_go_out)
            sval = stat_write_val_out;
        if (arr_read_req_out)
            n_rrq++;
        if (arr_data_valid_out && arr_data_rd_ready_in)
            last_wd = arr_data_out;
    end
    function automatic logic [15:0] sv(input logic l, input logic b);
        sv = {8'h00, nv_lock_in, 3'b000, nv_prot_in, l, b};
    endfunction
    task automatic chk(input string w, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fr(input int n, input logic [31:0] v,
                      input int x = 0, input logic p = 1'b0);
        i_mst.sel(1'b0);
        for (int i = 0; i < n; i++)
            i_mst.shift(8, v[31 - 8 * i -: 8], rx);
        i_mst.shift(x, 8'hff, rx);
        if (p)
            i_mst.pause(1'b0);
        i_mst.sel(1'b1);
        i_mst.pause(1'b1);
    endtask
    task automatic stat(input logic [15:0] e);
        i_mst.sel(1'b0);
        i_mst.shift(8, `SEP_OP_STAT_READ, rx);
        repeat (2)
        begin
            i_mst.shift(8, 8'h00, rx);
            chk("status", e, {8'h00, rx});
        end
        i_mst.sel(1'b1);
    endtask
    task automatic fin;
        write_done_in = 1'b1;
        @(negedge clk_sys_in);
        write_done_in = 1'b0;
    endtask
    task automatic t_latch;
        stat(sv(0, 0));
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        stat(sv(1, 0));
        fr(1, {`SEP_OP_CLR_LATCH, 24'h0});
        stat(sv(0, 0));
        fr(2, {8'hff, `SEP_OP_SET_LATCH, 16'h0});
        stat(sv(0, 0));
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        nrst_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        stat(sv(0, 0));
        $display("t_latch done");
    endtask
    task automatic t_prot;
        logic [23:0] tb [6];
        int          n;
        tb = '{24'h0ffff1, 24'h1c0000, 24'h1bfff1, 24'h280000,
               24'h27fff1, 24'h300000};
        n = n_awr;
        fr(4, {`SEP_OP_ARR_WRITE, 24'hffff5a});
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        fr(4, {`SEP_OP_ARR_WRITE, 24'h010011}, 1);
        chk("refused go", 16'h0, 16'(n_awr - n));
        foreach (tb[i])
        begin
            nv_prot_in = tb[i][21:20];
            n = n_awr;
            fr(1, {`SEP_OP_SET_LATCH, 24'h0});
            fr(4, {`SEP_OP_ARR_WRITE, tb[i][19:4], 8'h5a});
            chk("write go", 16'(tb[i][0]), 16'(n_awr - n));
            if (tb[i][0])
            begin
                chk("addr", tb[i][19:4], addr_out);
                stat(sv(1, 1));
                fin;
                stat(sv(0, 0));
            end
        end
        fr(1, {`SEP_OP_CLR_LATCH, 24'h0});
        $display("t_prot done");
    endtask
    task automatic t_swr;
        int n;
        n = n_swr;
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        fr(2, {`SEP_OP_STAT_WRITE, 8'h8c, 16'h0});
        chk("stat go", 16'h1, 16'(n_swr - n));
        chk("stat val", 16'h008c, {8'h00, sval});
        fin;
        nv_lock_in = 1'b1;
        nguard_in = 1'b0;
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        fr(2, {`SEP_OP_STAT_WRITE, 8'h00, 16'h0});
        chk("locked go", 16'h1, 16'(n_swr - n));
        stat(sv(1, 0));
        nguard_in = 1'b1;
        nv_lock_in = 1'b0;
        fr(1, {`SEP_OP_CLR_LATCH, 24'h0});
        $display("t_swr done");
    endtask
    task automatic t_pause;
        int         n;
        logic [7:0] hi;
        nv_prot_in = 2'b00;
        i_mst.sel(1'b0);
        i_mst.shift(4, `SEP_OP_SET_LATCH, rx);
        i_mst.pause(1'b0);
        i_mst.shift(3, 8'hff, rx);
        i_mst.pause(1'b1);
        i_mst.shift(4, (`SEP_OP_SET_LATCH) << 4, rx);
        i_mst.sel(1'b1);
        stat(sv(1, 0));
        i_mst.sel(1'b0);
        i_mst.shift(8, `SEP_OP_STAT_READ, rx);
        i_mst.shift(3, 8'h00, rx);
        hi = rx;
        i_mst.pause(1'b0);
        i_mst.shift(2, 8'hff, rx);
        i_mst.pause(1'b1);
        i_mst.shift(5, 8'h00, rx);
        chk("paused status", sv(1, 0), {8'h00, hi[2:0], rx[4:0]});
        i_mst.sel(1'b1);
        n = n_awr;
        fr(4, {`SEP_OP_ARR_WRITE, 24'h020033}, 0, 1'b1);
        chk("paused go", 16'h1, 16'(n_awr - n));
        stat(sv(1, 1));
        fin;
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        fr(0, 32'h0, 4, 1'b1);
        stat(sv(1, 0));
        $display("t_pause done");
    endtask
    task automatic t_read;
        int n;
        n = n_rrq;
        i_mst.sel(1'b0);
        i_mst.shift(8, `SEP_OP_ARR_READ, rx);
        i_mst.shift(8, 8'h12, rx);
        i_mst.shift(8, 8'hff, rx);
        i_mst.shift(8, 8'h00, rx);
        chk("read first", 16'h00ed, {8'h00, rx});
        i_mst.shift(8, 8'h00, rx);
        chk("read next", 16'h0013, {8'h00, rx});
        i_mst.sel(1'b1);
        chk("read addr", 16'h1301, addr_out);
        chk("read reqs", 16'h0003, 16'(n_rrq - n));
        $display("t_read done");
    endtask
    task automatic t_fifo;
        arr_data_rd_ready_in = 1'b0;
        fr(1, {`SEP_OP_SET_LATCH, 24'h0});
        i_mst.sel(1'b0);
        i_mst.shift(8, `SEP_OP_ARR_WRITE, rx);
        i_mst.shift(8, 8'h01, rx);
        i_mst.shift(8, 8'h00, rx);
        for (int i = 1; i <= 16; i++)
            i_mst.shift(8, 8'(i), rx);
        chk("full", 16'h1, {15'h0, fifo_full_out});
        i_mst.sel(1'b1);
        arr_data_rd_ready_in = 1'b1;
        repeat (40) @(negedge clk_sys_in);
        chk("drained", 16'h0, {15'h0, arr_data_valid_out});
        chk("last data", 16'h0010, {8'h00, last_wd});
        fin;
        $display("t_fifo done");
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys_in);
        failures++;
        close_out;
    end
    initial
    begin
        nrst_in = 1'b0;
        nguard_in = 1'b1;
        write_done_in = 1'b0;
        nv_prot_in = 2'b00;
        nv_lock_in = 1'b0;
        arr_data_rd_ready_in = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        t_latch;
        t_prot;
        t_swr;
        t_pause;
        t_read;
        t_fifo;
        close_out;
    end
endmodule
`default_nettype wire
